// *** clkout_pkg.sv ***
// Package with register map, field layout and encodings for the clock output channel.
package clkout_pkg;
   localparam logic [3:0]  ADDR_DIV_CONFIG    = 4'h0;
   localparam logic [3:0]  ADDR_DRV_ENABLE    = 4'h4;
   localparam logic [3:0]  ADDR_DRV_MODE      = 4'h8;
   localparam logic [3:0]  ADDR_STATUS        = 4'hC;
   localparam int          RATIO_W            = 14;
   localparam logic [13:0] RATIO_RESET        = 14'h0069;
   localparam logic [13:0] RATIO_MIN          = 14'h000A;
   localparam int          REG_ON_BIT         = 15;
   localparam logic        REG_ON_RESET       = 1'h1;
   localparam int          PD_BIT             = 0;
   localparam int          DIS_BIT            = 1;
   localparam int          DSTATE_LSB         = 2;
   localparam int          MODE_LSB           = 0;
   localparam logic [1:0]  DSTATE_LOWLOW      = 2'h0;
   localparam logic [1:0]  DSTATE_LOWHIGH     = 2'h1;
   localparam logic [1:0]  DSTATE_HIZ         = 2'h2;
   localparam logic [1:0]  DSTATE_RUN         = 2'h3;
   localparam logic [1:0]  MODE_HCSL          = 2'h0;
   localparam logic [1:0]  MODE_LVDS          = 2'h2;
   localparam logic [1:0]  MODE_CMOS          = 2'h3;
   localparam logic [1:0]  MODE_RESET         = 2'h0;
   typedef enum logic [1:0] {
      DRV_OFF     = 2'b00,
      DRV_RUN     = 2'b01,
      DRV_HOLD    = 2'b11
   } drv_state_t;
endpackage

// *** clk_divider.sv ***
// Integer clock divider producing a near-50 percent duty output.
`timescale 1ns/1ps
`default_nettype none
module clk_divider #(
   parameter int RW = 14
) (
   input  wire logic          ref_clk_in,
   input  wire logic          reset_in,
   input  wire logic          run_in,
   input  wire logic [RW-1:0] ratio_in,
   output logic               clk_div_out
);
   logic [RW-1:0] count_q, count_d;
   logic          div_q, div_d;

   // The count must reach past the smallest legal ratio of ten.
   if (RW < 4) begin : g_bad_width
      $error("RW is too narrow for the smallest legal ratio");
   end

   always_comb begin
      count_d = count_q;
      div_d   = div_q;
      if (!run_in) begin
         count_d = '0;
         div_d   = 1'b0;
      end else if (count_q >= ratio_in - RW'(1)) begin
         count_d = '0;
         div_d   = 1'b0;
      end else begin
         count_d = count_q + RW'(1);
         if (count_q == (ratio_in >> 1) - RW'(1)) begin
            div_d = 1'b1;
         end
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (reset_in) begin
         count_q <= '0;
         div_q   <= 1'b0;
      end else begin
         count_q <= count_d;
         div_q   <= div_d;
      end
   end

   assign clk_div_out = div_q;
endmodule
`default_nettype wire

// *** clkout_channel.sv ***
// Clock output channel: register port, divider and differential driver pin control.
//
// Overview of operation
// - Divider divides by 14-bit ratio, reset 0x69; ratios under ten are invalid.
// - Top bit of divider config turns divider regulator on; reset value one.
// - Force-off bit one puts the driver in its disabled state regardless of external enable; power-down wins.
// - Disabled state zero holds both pins low, LVDS holds true low, complement high.
// - Disabled state three keeps the driver toggling, for debug only.
// - Power-down tri-states both pins and ignores all output-enable control.
// - Driver type code: zero HCSL, two LVDS, three CMOS, one reserved.
`timescale 1ns/1ps
`default_nettype none
module clkout_channel
   import clkout_pkg::*;
#(
   parameter int RATIO_WIDTH = clkout_pkg::RATIO_W
) (
   input  wire logic       ref_clk_in,
   input  wire logic       reset_in,
   input  wire logic [3:0] addr_in,
   input  wire logic [15:0] wdata_in,
   input  wire logic       wr_in,
   input  wire logic       rd_in,
   input  wire logic       ext_enable_in,
   output logic [15:0]     rdata_out,
   output logic            divider_regulator_on_out,
   output logic            clock_pin_true_out,
   output logic            clock_pin_complement_out,
   output logic            clock_pin_true_oe_n_out,
   output logic            clock_pin_complement_oe_n_out
);
   if (RATIO_WIDTH != RATIO_W) begin : g_bad_ratio_width
      $error("RATIO_WIDTH must equal the 14-bit ratio field");
   end

   ////////////////////////////////////////////////////////////////////////////
   logic [13:0] ratio_q, ratio_d;
   logic        reg_on_q, reg_on_d;
   logic        pd_q, pd_d;
   logic        dis_q, dis_d;
   logic [1:0]  dstate_q, dstate_d;
   logic [1:0]  mode_q, mode_d;
   logic [15:0] rdata_q, rdata_d;
   drv_state_t  state_q, state_d;
   logic        tp_q, tp_d, cp_q, cp_d, toe_q, toe_d, coe_q, coe_d;
   logic        clk_div;
   logic        ratio_ok;

   function automatic logic [15:0] read_mux(input logic [3:0] a);
      case (a)
         ADDR_DIV_CONFIG: read_mux = {reg_on_q, 1'b0, ratio_q};
         ADDR_DRV_ENABLE: read_mux = {12'h000, dstate_q, dis_q, pd_q};
         ADDR_DRV_MODE:   read_mux = {14'h0000, mode_q};
         ADDR_STATUS:     read_mux = {13'h0000, ratio_ok, state_q};
         default:         read_mux = 16'h0000;
      endcase
   endfunction

   // Software must not program small ratios; the status word flags it rather than clamping.
   assign ratio_ok = (ratio_q >= RATIO_MIN);

   always_comb begin
      ratio_d  = ratio_q;
      reg_on_d = reg_on_q;
      pd_d     = pd_q;
      dis_d    = dis_q;
      dstate_d = dstate_q;
      mode_d   = mode_q;
      rdata_d  = 16'h0000;
      if (wr_in) begin
         case (addr_in)
            ADDR_DIV_CONFIG: begin
               ratio_d  = wdata_in[RATIO_W-1:0];
               reg_on_d = wdata_in[REG_ON_BIT];
            end
            ADDR_DRV_ENABLE: begin
               pd_d     = wdata_in[PD_BIT];
               dis_d    = wdata_in[DIS_BIT];
               dstate_d = wdata_in[DSTATE_LSB +: 2];
            end
            ADDR_DRV_MODE: mode_d = wdata_in[MODE_LSB +: 2];
            default: ;
         endcase
      end
      if (rd_in) begin
         rdata_d = read_mux(addr_in);
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (reset_in) begin
         ratio_q  <= RATIO_RESET;
         reg_on_q <= REG_ON_RESET;
         pd_q     <= 1'b0;
         dis_q    <= 1'b0;
         dstate_q <= DSTATE_LOWLOW;
         mode_q   <= MODE_RESET;
         rdata_q  <= 16'h0000;
      end else begin
         ratio_q  <= ratio_d;
         reg_on_q <= reg_on_d;
         pd_q     <= pd_d;
         dis_q    <= dis_d;
         dstate_q <= dstate_d;
         mode_q   <= mode_d;
         rdata_q  <= rdata_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // The divider stops while its regulator is off, since it has no supply then.
   clk_divider #(
      .RW (RATIO_WIDTH)
   ) u_div (
      .ref_clk_in  (ref_clk_in),
      .reset_in    (reset_in),
      .run_in      (reg_on_q),
      .ratio_in    (ratio_q),
      .clk_div_out (clk_div)
   );

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      if (pd_q) begin
         state_d = DRV_OFF;
      end else if (dis_q || !ext_enable_in) begin
         state_d = DRV_HOLD;
      end else begin
         state_d = DRV_RUN;
      end
   end

   // Pin levels; an enable of zero means the pin is driven.
   always_comb begin
      tp_d  = 1'b0;
      cp_d  = 1'b0;
      toe_d = 1'b0;
      coe_d = 1'b0;
      case (state_q)
         DRV_OFF: begin
            toe_d = 1'b1;
            coe_d = 1'b1;
         end
         DRV_RUN: begin
            tp_d = clk_div;
            cp_d = ~clk_div;
         end
         DRV_HOLD: begin
            case (dstate_q)
               DSTATE_LOWLOW: cp_d = (mode_q == MODE_LVDS);
               DSTATE_LOWHIGH: cp_d = 1'b1;
               DSTATE_HIZ: begin
                  toe_d = 1'b1;
                  coe_d = 1'b1;
               end
               DSTATE_RUN: begin
                  tp_d = clk_div;
                  cp_d = ~clk_div;
               end
               default: ;
            endcase
         end
         default: begin
            toe_d = 1'b1;
            coe_d = 1'b1;
         end
      endcase
   end

   always_ff @(posedge ref_clk_in) begin
      if (reset_in) begin
         state_q <= DRV_OFF;
         tp_q    <= 1'b0;
         cp_q    <= 1'b0;
         toe_q   <= 1'b1;
         coe_q   <= 1'b1;
      end else begin
         state_q <= state_d;
         tp_q    <= tp_d;
         cp_q    <= cp_d;
         toe_q   <= toe_d;
         coe_q   <= coe_d;
      end
   end

   assign rdata_out                     = rdata_q;
   assign divider_regulator_on_out      = reg_on_q;
   assign clock_pin_true_out            = tp_q;
   assign clock_pin_complement_out      = cp_q;
   assign clock_pin_true_oe_n_out       = toe_q;
   assign clock_pin_complement_oe_n_out = coe_q;
endmodule
`default_nettype wire

// *** clkout_assertions.sv ***
// Checker for the clock output channel register port and pin behaviour.
`timescale 1ns/1ps
`default_nettype none
module clkout_assertions
   import clkout_pkg::*;
(
   input wire logic        ref_clk_in,
   input wire logic        reset_in,
   input wire logic [3:0]  addr_in,
   input wire logic [15:0] wdata_in,
   input wire logic        wr_in,
   input wire logic        rd_in,
   input wire logic        ext_enable_in,
   input wire logic [15:0] rdata_out,
   input wire logic        divider_regulator_on_out,
   input wire logic        clock_pin_true_out,
   input wire logic        clock_pin_complement_out,
   input wire logic        clock_pin_true_oe_n_out,
   input wire logic        clock_pin_complement_oe_n_out
);
   logic [3:0] en_q;
   logic [1:0] mode_q;
   wire        dis = en_q[DIS_BIT] | ~ext_enable_in;
   wire        on_w = wdata_in[REG_ON_BIT];
   wire [1:0]  oe = {clock_pin_true_oe_n_out, clock_pin_complement_oe_n_out};
   wire [1:0]  pin = {clock_pin_true_out, clock_pin_complement_out};
   // Shadow of the enable and mode registers, taken from the write port alone.
   always_ff @(posedge ref_clk_in) begin
      if (reset_in) begin
         en_q   <= 4'h0;
         mode_q <= MODE_RESET;
      end else if (wr_in && addr_in == ADDR_DRV_ENABLE) begin
         en_q <= wdata_in[3:0];
      end else if (wr_in && addr_in == ADDR_DRV_MODE) begin
         mode_q <= wdata_in[1:0];
      end
   end
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (reset_in);
   // Three quiet cycles leave room for the two-cycle pin path after any change.
   // Reset is in the quiet set, so the pins' reset levels are never judged just after release.
   sequence settled;
      $stable({en_q, mode_q, ext_enable_in, reset_in}) [*3];
   endsequence
   sequence held(logic [1:0] s);
      settled ##0 (!en_q[PD_BIT] && dis && en_q[3:2] == s);
   endsequence
   reg_on_a: assert property (wr_in && addr_in == ADDR_DIV_CONFIG |=> divider_regulator_on_out == $past(on_w))
      else $error("regulator enable not taken from write");
   pd_tri_a: assert property (settled ##0 en_q[PD_BIT] |-> oe == 2'h3)
      else $error("powered down driver not tri-stated");
   run_drive_a: assert property (settled ##0 (!en_q[PD_BIT] && !dis) |-> oe == 2'h0 && pin[1] != pin[0])
      else $error("enabled driver not driving clock");
   low_low_a: assert property (held(DSTATE_LOWLOW) ##0 mode_q != MODE_LVDS |-> oe == 2'h0 && pin == 2'h0)
      else $error("disabled state zero not low low");
   lvds_hold_a: assert property (held(DSTATE_LOWLOW) ##0 mode_q == MODE_LVDS |-> oe == 2'h0 && pin == 2'h1)
      else $error("lvds disabled state not low high");
   low_high_a: assert property (held(DSTATE_LOWHIGH) |-> oe == 2'h0 && pin == 2'h1)
      else $error("disabled state one not low high");
   hiz_hold_a: assert property (held(DSTATE_HIZ) |-> oe == 2'h3)
      else $error("disabled state two not tri-stated");
   debug_run_a: assert property (held(DSTATE_RUN) |-> oe == 2'h0 && pin[1] != pin[0])
      else $error("debug disabled state not toggling");
endmodule
bind clkout_channel clkout_assertions u_chk (.ref_clk_in, .reset_in, .addr_in, .wdata_in, .wr_in, .rd_in,
   .ext_enable_in, .rdata_out, .divider_regulator_on_out, .clock_pin_true_out, .clock_pin_complement_out,
   .clock_pin_true_oe_n_out, .clock_pin_complement_oe_n_out);
`default_nettype wire

// *** clk_sink_model.sv ***
// Clock receiver model that resolves the true pin and measures its period.
`timescale 1ns/1ps
`default_nettype none
module clk_sink_model (
   input  wire logic   ref_clk_in,
   input  wire logic   pin_in,
   input  wire logic   oe_n_in,
   output logic [15:0] period_out
);
   wire         line = oe_n_in ? 1'bz : pin_in;
   logic        last_q = 1'b0;
   logic [15:0] cnt_q = 16'h0000;
   wire         rise = line === 1'b1 && last_q !== 1'b1;
   initial period_out = 16'h0000;
   // A floating line clears the period, so a stale figure never outlives a tri-state.
   always @(posedge ref_clk_in) begin
      last_q <= line;
      cnt_q <= rise ? 16'h0001 : cnt_q + 16'h0001;
      if (line === 1'bz) period_out <= 16'h0000;
      else if (rise) period_out <= cnt_q;
   end
endmodule
`default_nettype wire

// *** tb_top.sv ***
// Self-checking testbench for the clock output channel.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import clkout_pkg::*;
   logic        ref_clk_in = 1'b0;
   logic        reset_in = 1'b1;
   logic [3:0]  addr_in = 4'h0;
   logic [15:0] wdata_in = 16'h0000;
   logic        wr_in = 1'b0;
   logic        rd_in = 1'b0;
   logic        ext_enable_in = 1'b1;
   logic [15:0] rdata_out, period;
   logic        divider_regulator_on_out, clock_pin_true_out, clock_pin_complement_out;
   logic        clock_pin_true_oe_n_out, clock_pin_complement_oe_n_out;
   int          bad_count = 0;
   int          num_checks = 0;
   always #5 ref_clk_in = ~ref_clk_in;
   clkout_channel u_dut (.ref_clk_in, .reset_in, .addr_in, .wdata_in, .wr_in, .rd_in, .ext_enable_in, .rdata_out,
      .divider_regulator_on_out, .clock_pin_true_out, .clock_pin_complement_out, .clock_pin_true_oe_n_out,
      .clock_pin_complement_oe_n_out);
   clk_sink_model u_sink (.ref_clk_in, .pin_in(clock_pin_true_out), .oe_n_in(clock_pin_true_oe_n_out),
      .period_out(period));
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk_in);
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      addr_in <= a;
      wdata_in <= d;
      wr_in <= 1'b1;
      tick(1);
      wr_in <= 1'b0;
      tick(1);
   endtask
   task automatic rd(input logic [3:0] a, input logic [15:0] e);
      addr_in <= a;
      rd_in <= 1'b1;
      tick(1);
      rd_in <= 1'b0;
      tick(1);
      check(rdata_out, e);
   endtask
   task automatic t_defaults;
      rd(ADDR_DIV_CONFIG, 16'h8069);
      rd(ADDR_DRV_ENABLE, 16'h0000);
      check(16'(divider_regulator_on_out), 16'h0001);
   endtask
   task automatic t_states;
      for (int m = 0; m < 4; m++) begin
         wr(ADDR_DRV_MODE, 16'(m));
         for (int s = 0; s < 3; s++) begin
            wr(ADDR_DRV_ENABLE, 16'(s * 4 + 2));
            tick(3);
            check(16'({clock_pin_true_oe_n_out, clock_pin_complement_oe_n_out}), (s == 2) ? 16'h3 : 16'h0);
            if (s < 2) check(16'({clock_pin_true_out, clock_pin_complement_out}),
               (s == 1 || m == 2) ? 16'h1 : 16'h0);
         end
      end
      rd(ADDR_DRV_MODE, 16'h0003);
   endtask
   task automatic t_ratio;
      wr(ADDR_DRV_ENABLE, 16'h0000);
      wr(ADDR_DIV_CONFIG, 16'h0069);
      tick(1);
      check(16'(divider_regulator_on_out), 16'h0000);
      wr(ADDR_DIV_CONFIG, 16'h8069);
      tick(330);
      check(period, 16'h0069);
      wr(ADDR_DIV_CONFIG, 16'h800A);
      tick(40);
      check(period, 16'h000A);
      rd(ADDR_STATUS, 16'h0005);
      wr(ADDR_DIV_CONFIG, 16'h8009);
      rd(ADDR_STATUS, 16'h0001);
      wr(ADDR_DIV_CONFIG, 16'h800A);
   endtask
   task automatic t_enable;
      wr(ADDR_DRV_ENABLE, 16'h0001);
      ext_enable_in <= 1'b0;
      tick(4);
      check(period, 16'h0000);
      wr(ADDR_DRV_ENABLE, 16'h000C);
      tick(40);
      check(period, 16'h000A);
      wr(ADDR_DRV_ENABLE, 16'h0000);
      tick(3);
      check(16'({clock_pin_true_out, clock_pin_true_oe_n_out}), 16'h0000);
      // A tri-state clears the sink's figure, so the last check cannot pass on a stale period.
      wr(ADDR_DRV_ENABLE, 16'h0008);
      tick(4);
      check(period, 16'h0000);
      ext_enable_in <= 1'b1;
      tick(40);
      check(period, 16'h000A);
   endtask
   task automatic test_done;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   initial begin
      tick(3);
      reset_in <= 1'b0;
      t_defaults;
      t_states;
      t_ratio;
      t_enable;
      test_done;
   end
   // The run needs about 560 cycles, so this limit only trips on a hang.
   initial begin
      #30000;
      bad_count++;
      test_done;
   end
endmodule
`default_nettype wire
